// ===== txmc_top.sv
// Purpose: transmit mode control and transmit process sequencer with wishbone registers
// Assumes: descriptor memory and transmit fifo sit outside, behind handshake ports
// Notes:   soft_rst_i is the software reset; rst_i is the hardware reset
//
// What this block does
// - full-packet gate set: transmit only with a whole frame buffered, threshold ignored.
// - heartbeat-off bit disables the heartbeat quality generator.
// - port choice bit: zero selects serial port, one selects media port.
// - hardware reset clears port choice; software reset leaves it alone.
// - capture resolve bit enables or disables capture-effect resolution.
// - two-bit threshold field picks one of four fifo threshold levels.
// - threshold mode starts above threshold, or on a shorter complete frame.
// - setting run command enters running state and checks the list.
// - start fetches from the list base, or from the retained position.
// - no descriptor acquirable after start: process suspends.
// - descriptor not owned: suspend and set buffer unavailable status flag.
// - start command acts only while the process is stopped.
// - clearing run stops after current frame and keeps the next position.
// - stop command acts only while running or suspended.
// - process state reported as three-bit code, fetch 001, suspended 110.
// - status bits 0 to 2 clear on writing one; zero does nothing.
`timescale 1ns/1ps

module txmc_top
  import txmc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        soft_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             desc_req_o,
  output logic      [31:0] desc_addr_o,
  input  wire logic        desc_ack_i,
  input  wire logic        desc_own_i,
  input  wire logic        desc_fail_i,
  input  wire logic        tx_poll_i,
  input  wire logic [10:0] fifo_level_i,
  input  wire logic        fifo_frame_full_i,
  output logic             tx_go_o,
  input  wire logic        tx_done_i,
  output logic             heartbeat_off_o,
  output logic             port_choice_o,
  output logic             capture_resolve_en_o,
  output logic      [1:0]  tx_threshold_level_o,
  output logic             full_packet_gate_o,
  output logic      [2:0]  tx_state_o
);

`include "txmc_consts.svh"

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  txmc_state_t state_q;
  txmc_state_t state_d;
  logic [31:0] op_q;
  logic [31:0] base_q;
  logic        base_new_q;
  logic [31:0] cur_ptr_q;
  logic        wb_req;
  logic        wr_en;
  logic [31:0] lane_mask;
  logic [31:0] op_wr;
  logic [31:0] rd_data;
  logic [10:0] thr_sel;
  logic        start_ok;
  logic        run;
  logic        any_rst;
  logic        desc_taken;
  logic        flag_done;
  logic        flag_stop;
  logic        flag_tbu;
  logic        clr_done;
  logic        clr_stop;
  logic        clr_tbu;
  logic        set_stop;
  logic        set_tbu;
  logic        set_done;
  logic [2:0]  code_d;

  assign any_rst    = rst_i | soft_rst_i;
  assign run        = op_q[`TXMC_BIT_RUN];
  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes land at the ack edge, so a master that waits on ack sees them in place
  assign wr_en      = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign lane_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign desc_taken = desc_req_o & (desc_ack_i | desc_fail_i);

  // unused bits 20 and 16 never reach the register, whatever software writes
  assign op_wr = ((op_q & ~lane_mask) | (wb_dat_i & lane_mask)) & `TXMC_OPMODE_MASK;

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  // one wait state: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      `TXMC_OFF_LIST_BASE: rd_data = base_q;
      `TXMC_OFF_OPMODE:    rd_data = op_q;
      `TXMC_OFF_STATUS: begin
        rd_data = `TXMC_STATUS_FIXED;
        rd_data[`TXMC_ST_STATE_LO +: 3] = tx_state_o;
        rd_data[`TXMC_ST_TX_DONE] = flag_done;
        rd_data[`TXMC_ST_TX_STOP] = flag_stop;
        rd_data[`TXMC_ST_TBU] = flag_tbu;
      end
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req & ~wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

  // ----------------------------------------
  // operation_mode register
  // ----------------------------------------
  // software reset keeps the port choice; write blocked during it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q <= `TXMC_OPMODE_RESET;
    end else if (soft_rst_i) begin
      op_q <= `TXMC_OPMODE_RESET;
      op_q[`TXMC_BIT_PORT] <= op_q[`TXMC_BIT_PORT];
    end else if (wr_en && wb_adr_i == `TXMC_OFF_OPMODE) begin
      op_q <= op_wr;
    end
  end

  // fields leave on flops of their own; timing-critical users see no decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      heartbeat_off_o      <= 1'b0;
      port_choice_o        <= 1'b0;
      capture_resolve_en_o <= 1'b0;
      tx_threshold_level_o <= 2'b00;
      full_packet_gate_o   <= 1'b0;
    end else begin
      heartbeat_off_o      <= op_q[`TXMC_BIT_HB_OFF];
      port_choice_o        <= op_q[`TXMC_BIT_PORT];
      capture_resolve_en_o <= op_q[`TXMC_BIT_CAPTURE];
      tx_threshold_level_o <= op_q[`TXMC_THR_HI:`TXMC_THR_LO];
      full_packet_gate_o   <= op_q[`TXMC_BIT_FULL_GATE];
    end
  end

  // ----------------------------------------
  // list base register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      base_q <= `TXMC_BASE_RESET;
    end else if (wr_en && wb_adr_i == `TXMC_OFF_LIST_BASE) begin
      base_q <= (base_q & ~lane_mask) | (wb_dat_i & lane_mask);
    end
  end

  // a fresh base replaces the retained position at the next start
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      base_new_q <= 1'b1;
    end else if (wr_en && wb_adr_i == `TXMC_OFF_LIST_BASE) begin
      base_new_q <= 1'b1;
    end else if (state_q == st_stopped && run) begin
      base_new_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // transmit start gate
  // ----------------------------------------
  always_comb begin
    thr_sel = `TXMC_THR_L0;
    unique case (op_q[`TXMC_THR_HI:`TXMC_THR_LO])
      2'b00: thr_sel = `TXMC_THR_L0;
      2'b01: thr_sel = `TXMC_THR_L1;
      2'b10: thr_sel = `TXMC_THR_L2;
      2'b11: thr_sel = `TXMC_THR_L3;
    endcase
  end

  // threshold field must stay put while running, so no glitch on the gate
  assign start_ok = op_q[`TXMC_BIT_FULL_GATE] ? fifo_frame_full_i
                  : (fifo_level_i > thr_sel) | fifo_frame_full_i;

  // ----------------------------------------
  // transmit process sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_stopped: begin
        if (run) begin
          state_d = st_fetch;
        end
      end
      st_fetch: begin
        if (desc_taken) begin
          if (!run) begin
            state_d = st_stopped;
          end else if (desc_fail_i || !desc_own_i) begin
            state_d = st_susp;
          end else begin
            state_d = st_queue;
          end
        end
      end
      st_queue: begin
        if (start_ok) begin
          state_d = st_xmit;
        end
      end
      st_xmit: begin
        if (tx_done_i) begin
          state_d = st_close;
        end
      end
      st_close: begin
        state_d = run ? st_fetch : st_stopped;
      end
      st_susp: begin
        if (!run) begin
          state_d = st_stopped;
        end else if (tx_poll_i) begin
          state_d = st_fetch;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      state_q <= st_stopped;
    end else begin
      state_q <= state_d;
    end
  end

  // request held from entry to fetch until the answer edge
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      desc_req_o <= 1'b0;
    end else begin
      desc_req_o <= (state_d == st_fetch) && !(state_q == st_fetch && desc_taken);
    end
  end

  // position: base or retained on start, next descriptor after each close
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      cur_ptr_q <= `TXMC_BASE_RESET;
    end else if (state_q == st_stopped && run && base_new_q) begin
      cur_ptr_q <= base_q;
    end else if (state_q == st_close) begin
      cur_ptr_q <= cur_ptr_q + `TXMC_DESC_STRIDE;
    end
  end

  assign desc_addr_o = cur_ptr_q;

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      tx_go_o <= 1'b0;
    end else begin
      tx_go_o <= (state_q == st_queue) && start_ok;
    end
  end

  always_comb begin
    code_d = `TXMC_PS_STOPPED;
    unique case (state_d)
      st_stopped: code_d = `TXMC_PS_STOPPED;
      st_fetch:   code_d = `TXMC_PS_FETCH;
      st_queue:   code_d = `TXMC_PS_QUEUE;
      st_xmit:    code_d = `TXMC_PS_XMIT;
      st_close:   code_d = `TXMC_PS_CLOSE;
      st_susp:    code_d = `TXMC_PS_SUSP;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      tx_state_o <= `TXMC_PS_STOPPED;
    end else begin
      tx_state_o <= code_d;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  assign set_done = (state_q == st_close);
  assign set_stop = (state_q != st_stopped) && (state_d == st_stopped);
  assign set_tbu  = (state_q == st_fetch) && desc_taken && run && !desc_fail_i && !desc_own_i;
  assign clr_done = wr_en && wb_adr_i == `TXMC_OFF_STATUS && wb_sel_i[0]
                    && wb_dat_i[`TXMC_ST_TX_DONE];
  assign clr_stop = wr_en && wb_adr_i == `TXMC_OFF_STATUS && wb_sel_i[0]
                    && wb_dat_i[`TXMC_ST_TX_STOP];
  assign clr_tbu  = wr_en && wb_adr_i == `TXMC_OFF_STATUS && wb_sel_i[0]
                    && wb_dat_i[`TXMC_ST_TBU];

  txmc_sticky u_flag_done (
    .clk_i  (clk_i),
    .rst_i  (any_rst),
    .set_i  (set_done),
    .clr_i  (clr_done),
    .flag_o (flag_done)
  );

  txmc_sticky u_flag_stop (
    .clk_i  (clk_i),
    .rst_i  (any_rst),
    .set_i  (set_stop),
    .clr_i  (clr_stop),
    .flag_o (flag_stop)
  );

  txmc_sticky u_flag_tbu (
    .clk_i  (clk_i),
    .rst_i  (any_rst),
    .set_i  (set_tbu),
    .clr_i  (clr_tbu),
    .flag_o (flag_tbu)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_full_gate_hold: assert property (@(posedge clk_i) disable iff (any_rst)
    (state_q == st_queue && op_q[`TXMC_BIT_FULL_GATE] && !fifo_frame_full_i) |=> !tx_go_o)
    else $error("transmit started without a full frame");

  chk_thr_start: assert property (@(posedge clk_i) disable iff (any_rst)
    (state_q == st_queue && !op_q[`TXMC_BIT_FULL_GATE] && fifo_level_i > thr_sel)
    |=> tx_go_o ##1 (state_q == st_xmit && !tx_go_o))
    else $error("threshold crossing did not start transmit");

  chk_short_frame: assert property (@(posedge clk_i) disable iff (any_rst)
    (state_q == st_queue && fifo_frame_full_i) |=> tx_go_o && tx_state_o == `TXMC_PS_XMIT)
    else $error("complete short frame not sent");

  chk_port_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_rst_i |=> op_q[`TXMC_BIT_PORT] == $past(op_q[`TXMC_BIT_PORT]))
    else $error("software reset changed port choice");

  chk_hw_clear: assert property (@(posedge clk_i)
    rst_i |=> !op_q[`TXMC_BIT_PORT] ##1 !port_choice_o)
    else $error("hardware reset left port choice set");

  chk_start_fetch: assert property (@(posedge clk_i) disable iff (any_rst)
    (state_q == st_stopped && run) |=> desc_req_o && tx_state_o == `TXMC_PS_FETCH)
    else $error("start did not fetch a descriptor");

  chk_not_owned: assert property (@(posedge clk_i) disable iff (any_rst)
    set_tbu |=> state_q == st_susp && flag_tbu && tx_state_o == `TXMC_PS_SUSP)
    else $error("unowned descriptor did not suspend");

  chk_fail_susp: assert property (@(posedge clk_i) disable iff (any_rst)
    (state_q == st_fetch && desc_req_o && desc_fail_i && run) |=> state_q == st_susp)
    else $error("failed acquisition did not suspend");

  chk_stop_susp: assert property (@(posedge clk_i) disable iff (any_rst)
    (state_q == st_susp && !run) |=> state_q == st_stopped && flag_stop)
    else $error("stop from suspended not taken");

  chk_tbu_clear: assert property (@(posedge clk_i) disable iff (any_rst)
    (flag_tbu && clr_tbu && !set_tbu) |=> !flag_tbu)
    else $error("buffer unavailable flag not cleared by one");

  chk_ptr_step: assert property (@(posedge clk_i) disable iff (any_rst)
    (state_q == st_close) |=> desc_addr_o == $past(desc_addr_o) + `TXMC_DESC_STRIDE)
    else $error("descriptor position not advanced");

  chk_mode_hold: assert property (@(posedge clk_i) disable iff (any_rst)
    !(wr_en && wb_adr_i == `TXMC_OFF_OPMODE) |=> $stable(op_q))
    else $error("mode register changed without a write");

endmodule

// ===== txmc_consts.svh
// Purpose: offsets, field positions, reset values and levels of the transmit mode control block
// Assumes: byte addresses on an 8-bit wishbone address, 32-bit data
// Notes:   definitions only
`ifndef TXMC_CONSTS_SVH
`define TXMC_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TXMC_OFF_LIST_BASE 8'h20
`define TXMC_OFF_STATUS    8'h28
`define TXMC_OFF_OPMODE    8'h30

// ----------------------------------------
// operation_mode fields
// ----------------------------------------
`define TXMC_BIT_FULL_GATE 21
`define TXMC_BIT_HB_OFF    19
`define TXMC_BIT_PORT      18
`define TXMC_BIT_CAPTURE   17
`define TXMC_THR_HI        15
`define TXMC_THR_LO        14
`define TXMC_BIT_RUN       13
`define TXMC_OPMODE_MASK   32'h002E_E000
`define TXMC_OPMODE_RESET  32'h0000_0000

// ----------------------------------------
// status_reg fields
// ----------------------------------------
`define TXMC_ST_TX_DONE    0
`define TXMC_ST_TX_STOP    1
`define TXMC_ST_TBU        2
`define TXMC_ST_STATE_LO   20
`define TXMC_STATUS_FIXED  32'hFC00_0000

// ----------------------------------------
// process state codes
// ----------------------------------------
`define TXMC_PS_STOPPED    3'h0
`define TXMC_PS_FETCH      3'h1
`define TXMC_PS_XMIT       3'h2
`define TXMC_PS_QUEUE      3'h3
`define TXMC_PS_SUSP       3'h6
`define TXMC_PS_CLOSE      3'h7

// ----------------------------------------
// fifo threshold levels in bytes, descriptor stride
// ----------------------------------------
`define TXMC_THR_L0        11'h048
`define TXMC_THR_L1        11'h060
`define TXMC_THR_L2        11'h080
`define TXMC_THR_L3        11'h0A0
`define TXMC_DESC_STRIDE   32'h0000_0010
`define TXMC_BASE_RESET    32'h0000_0000

`endif

// ===== txmc_pkg.sv
// Purpose: types of the transmit mode control block
// Assumes: nothing
// Notes:   one-hot process states
package txmc_pkg;

  // ----------------------------------------
  // transmit process states
  // ----------------------------------------
  typedef enum logic [5:0] {
    st_stopped = 6'h01,
    st_fetch   = 6'h02,
    st_queue   = 6'h04,
    st_xmit    = 6'h08,
    st_close   = 6'h10,
    st_susp    = 6'h20
  } txmc_state_t;

endpackage

// ===== txmc_sticky.sv
// Purpose: one sticky status flag, cleared by software writing one
// Assumes: set and clear are single-cycle terms
// Notes:   set wins over clear
`timescale 1ns/1ps

module txmc_sticky (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  // ----------------------------------------
  // flag
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule

// ===== txmc_desc_mem.sv
// Purpose: descriptor memory seen from the transmit process
// Assumes: one fetch outstanding, request held until answered
// Notes:   latency, ownership and failure are set by the bench
`timescale 1ns/1ps

module txmc_desc_mem (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic [3:0] lat_i,
  input  wire logic       own_set_i,
  input  wire logic       fail_set_i,
  output logic            ack_o,
  output logic            own_o,
  output logic            fail_o
);
  logic [3:0] cnt_q;
  logic       done_q;

  // ----------------------------------------
  // answer after lat_i cycles, once per request
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    ack_o  <= 1'b0;
    fail_o <= 1'b0;
    // toggles outside an answer so a stale own bit is never seen
    own_o  <= ~own_o;
    if (rst_i) begin
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
      own_o  <= 1'b0;
    end else if (!req_i) begin
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
    end else if (!done_q && cnt_q >= lat_i) begin
      ack_o  <= ~fail_set_i;
      fail_o <= fail_set_i;
      own_o  <= own_set_i;
      done_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// ===== tb_tx_mode_control.sv
// Purpose: self-checking bench of the transmit mode control block
// Assumes: wishbone answers one cycle after taking a request
// Notes:   every wait is bounded
`timescale 1ns/1ps
`include "txmc_consts.svh"

module tb_tx_mode_control;
  logic        clk_i = 0, rst_i = 1, soft_rst_i = 0, tx_poll_i = 0, tx_done_i = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, fifo_frame_full_i = 0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0, lat = 4'h3, sel = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, desc_addr_o, rd;
  logic [10:0] fifo_level_i = 11'h000;
  logic        wb_ack_o, desc_req_o, desc_ack_i, desc_own_i, desc_fail_i, tx_go_o;
  logic        heartbeat_off_o, port_choice_o, capture_resolve_en_o, full_packet_gate_o;
  logic        own_set = 1, fail_set = 0;
  logic [1:0]  tx_threshold_level_o;
  logic [2:0]  tx_state_o;
  int          num_errors = 0, compares = 0, go_cnt = 0;
  logic [10:0] thr_tab [4] = '{`TXMC_THR_L0, `TXMC_THR_L1, `TXMC_THR_L2, `TXMC_THR_L3};

  txmc_top txmc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .desc_req_o(desc_req_o), .desc_addr_o(desc_addr_o), .desc_ack_i(desc_ack_i),
    .desc_own_i(desc_own_i), .desc_fail_i(desc_fail_i), .tx_poll_i(tx_poll_i),
    .fifo_level_i(fifo_level_i), .fifo_frame_full_i(fifo_frame_full_i), .tx_go_o(tx_go_o),
    .tx_done_i(tx_done_i), .heartbeat_off_o(heartbeat_off_o), .port_choice_o(port_choice_o),
    .capture_resolve_en_o(capture_resolve_en_o), .tx_threshold_level_o(tx_threshold_level_o),
    .full_packet_gate_o(full_packet_gate_o), .tx_state_o(tx_state_o));

  txmc_desc_mem txmc_desc_mem_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(desc_req_o),
    .lat_i(lat), .own_set_i(own_set), .fail_set_i(fail_set), .ack_o(desc_ack_i),
    .own_o(desc_own_i), .fail_o(desc_fail_i));

  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (tx_go_o === 1'b1) go_cnt <= go_cnt + 1;

  // ----------------------------------------
  // report and bus helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    num_errors++;
    $display("mismatch %s expected answer seen timeout", nm);
    stop_test();
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
    wb_sel_i <= sel;
    i = 0;
    do begin @(posedge clk_i); i++; end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) hang("wb ack");
    rd = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
  endtask

  task automatic wait_st(input logic [2:0] c, input string nm);
    int i;
    i = 0;
    while (tx_state_o !== c && i < 60) begin @(posedge clk_i); i++; end
    if (tx_state_o !== c) hang(nm);
  endtask

  // one frame from start to stop; run bit cleared mid-frame
  task automatic frame(input logic [31:0] md, input logic [10:0] l_no, input logic [10:0] l_go,
                       input logic f_go, input logic [31:0] ea);
    int g0, i;
    g0 = go_cnt;
    wb(1, `TXMC_OFF_OPMODE, md | 32'h0000_2000);
    wait_st(`TXMC_PS_FETCH, "fetch state");
    cmp("desc addr", ea, desc_addr_o);
    cmp("thr pins", {30'h0, md[15:14]}, {30'h0, tx_threshold_level_o});
    cmp("gate pin", {31'h0, md[21]}, {31'h0, full_packet_gate_o});
    wait_st(`TXMC_PS_QUEUE, "queue state");
    fifo_level_i <= l_no; fifo_frame_full_i <= 0;
    repeat (6) @(posedge clk_i);
    cmp("early go", 0, go_cnt - g0);
    fifo_level_i <= l_go; fifo_frame_full_i <= f_go;
    i = 0;
    while (go_cnt == g0 && i < 40) begin @(posedge clk_i); i++; end
    cmp("go count", 1, go_cnt - g0);
    wb(1, `TXMC_OFF_OPMODE, md);
    @(posedge clk_i) tx_done_i <= 1; fifo_level_i <= 0; fifo_frame_full_i <= 0;
    @(posedge clk_i) tx_done_i <= 0;
    wait_st(`TXMC_PS_STOPPED, "stopped state");
    cmp("no refetch", 0, {31'h0, desc_req_o});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    wb(0, `TXMC_OFF_OPMODE, 0); cmp("op reset", `TXMC_OPMODE_RESET, rd);
    wb(0, `TXMC_OFF_STATUS, 0); cmp("status reset", 32'hFC00_0000, rd & 32'hFC70_0004);
    wb(0, 8'h04, 0); cmp("unmapped read", 0, rd);
    // bits 20 and 16 written on purpose to see them dropped
    wb(1, `TXMC_OFF_OPMODE, 32'h003F_C000);
    wb(0, `TXMC_OFF_OPMODE, 0); cmp("op readback", 32'h002E_C000, rd);
    repeat (2) @(posedge clk_i);
    cmp("hb pin", 1, {31'h0, heartbeat_off_o});
    cmp("port pin", 1, {31'h0, port_choice_o});
    cmp("capture pin", 1, {31'h0, capture_resolve_en_o});
    cmp("gate pin", 1, {31'h0, full_packet_gate_o});
    @(posedge clk_i) soft_rst_i <= 1;
    @(posedge clk_i) soft_rst_i <= 0;
    wb(0, `TXMC_OFF_OPMODE, 0); cmp("op after soft", 32'h0004_0000, rd);
    cmp("port soft", 1, {31'h0, port_choice_o});
    cmp("capture soft", 0, {31'h0, capture_resolve_en_o});
    wb(1, `TXMC_OFF_OPMODE, 0); repeat (2) @(posedge clk_i);
    cmp("port serial", 0, {31'h0, port_choice_o});
    wb(1, `TXMC_OFF_OPMODE, 32'h000C_0000);
    @(posedge clk_i) rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(posedge clk_i);
    cmp("port hw reset", 0, {31'h0, port_choice_o});
    wb(0, `TXMC_OFF_OPMODE, 0); cmp("op hw reset", 0, rd);
    $display("test regs done");
  endtask

  task automatic t_thr();
    int k;
    wb(1, `TXMC_OFF_LIST_BASE, 32'h0000_0100);
    lat <= 4'h8;
    for (k = 0; k < 4; k++)
      frame(32'(k) << 14, thr_tab[k], thr_tab[k] + 11'h001, 0, 32'h100 + 32'(16 * k));
    lat <= 4'h0;
    frame(32'h0000_C000, 11'h008, 11'h008, 1, 32'h0000_0140);
    frame(32'h0020_0000, 11'h7FF, 11'h7FF, 1, 32'h0000_0150);
    wb(0, `TXMC_OFF_STATUS, 0); cmp("frame flag", 1, rd & 32'h1);
    cmp("stop flag", 2, rd & 32'h2);
    wb(1, `TXMC_OFF_STATUS, 32'h3);
    wb(0, `TXMC_OFF_STATUS, 0); cmp("frame flag clr", 0, rd & 32'h3);
    $display("test threshold done");
  endtask

  task automatic t_susp();
    lat <= 4'h3; own_set <= 0;
    wb(1, `TXMC_OFF_LIST_BASE, 32'h0000_0200);
    wb(1, `TXMC_OFF_OPMODE, 32'h0000_2000);
    wait_st(`TXMC_PS_SUSP, "suspend state");
    wb(0, `TXMC_OFF_STATUS, 0); cmp("unavail flag", 4, rd & 32'h4);
    cmp("state field", 6, (rd >> 20) & 32'h7);
    wb(1, `TXMC_OFF_STATUS, 0);
    wb(0, `TXMC_OFF_STATUS, 0); cmp("flag zero write", 4, rd & 32'h4);
    // clear with lane 0 off must leave the flag set
    sel <= 4'hE;
    wb(1, `TXMC_OFF_STATUS, 32'h4);
    sel <= 4'hF;
    wb(0, `TXMC_OFF_STATUS, 0); cmp("lane zero only", 4, rd & 32'h4);
    wb(1, `TXMC_OFF_STATUS, 32'h4);
    wb(0, `TXMC_OFF_STATUS, 0); cmp("flag clear", 0, rd & 32'h4);
    wb(1, `TXMC_OFF_OPMODE, 32'h0000_2000); repeat (4) @(posedge clk_i);
    cmp("start ignored", 6, {29'h0, tx_state_o});
    @(posedge clk_i) tx_poll_i <= 1;
    @(posedge clk_i) tx_poll_i <= 0;
    wait_st(`TXMC_PS_FETCH, "poll fetch");
    wait_st(`TXMC_PS_SUSP, "poll suspend");
    wb(1, `TXMC_OFF_OPMODE, 0);
    wait_st(`TXMC_PS_STOPPED, "stop from suspend");
    wb(0, `TXMC_OFF_STATUS, 0); cmp("stop flag susp", 2, rd & 32'h2);
    own_set <= 1; fail_set <= 1;
    wb(1, `TXMC_OFF_OPMODE, 32'h0000_2000);
    wait_st(`TXMC_PS_FETCH, "fail fetch");
    cmp("retained addr", 32'h0000_0200, desc_addr_o);
    wait_st(`TXMC_PS_SUSP, "fail suspend");
    wb(1, `TXMC_OFF_OPMODE, 0);
    wait_st(`TXMC_PS_STOPPED, "fail stop");
    fail_set <= 0;
    $display("test suspend done");
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t_regs();
    t_thr();
    t_susp();
    stop_test();
  end
endmodule
